// ---- design/lcd_drive_pkg.sv ----
// Constants for the segment LCD drive control block
package lcd_drive_pkg;
   // ------------------------------------------------------------
   // Register map (byte offsets on the bus)
   // ------------------------------------------------------------
   localparam logic [7:0] OFS_PIN_CTRL = 8'h00;
   localparam logic [7:0] OFS_CONTROL = 8'h04;
   localparam logic [7:0] OFS_STANDBY = 8'h08;
   localparam logic [7:0] OFS_STATUS = 8'h0c;
   // ------------------------------------------------------------
   // Reset values and fixed bits
   // ------------------------------------------------------------
   localparam logic [7:0] PIN_CTRL_RESET = 8'h00;
   localparam logic [7:0] CONTROL_RESET = 8'h80;
   localparam logic [7:0] CONTROL_FIXED_ONES = 8'h80;
   localparam logic [7:0] STANDBY_FIXED_ONES = 8'hfe;
   localparam logic STANDBY_N_RESET = 1'b1;
   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int DUTY_HI_BIT = 7;
   localparam int DUTY_LO_BIT = 6;
   localparam int COM_PAR_BIT = 5;
   localparam int EXP_SEL_BIT = 4;
   localparam int POWER_SW_BIT = 6;
   localparam int ACTIVATE_BIT = 5;
   localparam int SHOW_BIT = 4;
   localparam int STANDBY_N_BIT = 0;
   // ------------------------------------------------------------
   // Pins and duty codes
   // ------------------------------------------------------------
   localparam int SEG_PINS = 40;
   localparam int GROUP_PINS = 8;
   localparam logic [1:0] DUTY_STATIC = 2'h0;
   localparam logic [1:0] DUTY_HALF = 2'h1;
   localparam logic [1:0] DUTY_THIRD = 2'h2;
   localparam logic [1:0] DUTY_QUARTER = 2'h3;
   // ------------------------------------------------------------
   // Frame timing, in operating clock ticks
   // ------------------------------------------------------------
   localparam int SUBCLK_HZ = 32768;
   localparam int SUB_FRAME_HZ = 128;
   localparam int SUB_FRAME_TICKS = SUBCLK_HZ / SUB_FRAME_HZ;
   localparam int SYS_FRAME_TICKS = 2 * SUB_FRAME_TICKS;
   // One phase per common; a third-duty frame is three quarter phases long
   localparam logic [8:0] SUB_QUARTER_PHASE = 9'(SUB_FRAME_TICKS / 4);
endpackage

// ---- design/lcd_segment_drive_control.sv ----
// Segment LCD drive control: register file, pin assignment and frame timing
`timescale 1ns/10ps
`default_nettype none

// Notes on behaviour
// - Expansion bit swaps top four pins to expansion
// - Expansion off, group zero: top pins are ports
// - Group field enables eight-pin groups from top
// - Expansion on needs group zero; else ports
// - Control top bit reads one, ignores writes
// - Control register resets to 0x80
// - Power switch bit turns drive supply on
// - Supply off when inactive or in standby
// - Activate clear halts, registers kept
// - Show bit clear outputs blank data
// - Clock field picks sub or system divider
// - System clock selections blank when clock stopped
// - Sub-clock selections give 128, 64, 32 Hz
// - Third duty frame is four thirds faster
// - Duty bits pick commons; parallel copies commons in static and half duty
// - Module standby bit low parks the module
module lcd_segment_drive_control (
   input wire logic clk,
   input wire logic reset,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic subclk_pin,
   input wire logic standby_mode,
   input wire logic system_clock_stopped,
   input wire logic [39:0] seg_data,
   output logic [39:0] seg_out,
   output logic [39:0] seg_oe,
   output logic [3:0] com_out,
   output logic drive_power_on,
   output logic frame_pulse
);

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   logic [7:0] pin_ctrl_r;
   logic [6:0] control_r;
   logic standby_n_r;
   logic wr_pend_r;
   logic [7:0] wr_addr_r;
   logic rd_wait_r;
   logic [7:0] rd_addr_r;
   logic [31:0] hrdata_r;
   logic hreadyout_r;
   logic [2:0] sub_sync_r;
   logic sub_level_r;
   logic sub_tick_r;
   logic [7:0] sys_div_r;
   logic [1:0] sub_div_r;
   logic [8:0] phase_cnt_r;
   logic [1:0] com_idx_r;
   logic [4:0] cfg_prev_r;
   logic alt_r;
   logic [39:0] seg_out_r;
   logic [39:0] seg_oe_r;
   logic [3:0] com_out_r;
   logic power_r;
   logic frame_r;

   logic [1:0] duty;
   logic com_par;
   logic exp_sel;
   logic [3:0] grp_sel;
   logic power_sw;
   logic activate;
   logic show;
   logic [3:0] clk_sel;
   logic use_sys;
   logic running;
   logic restart;
   logic op_tick;
   logic [8:0] phase_len;
   logic [1:0] last_com;
   logic [2:0] groups_on;
   logic exp_active;
   logic phase_end;
   logic [7:0] sys_mask;
   logic addr_ok;

   assign duty = {pin_ctrl_r[lcd_drive_pkg::DUTY_HI_BIT], pin_ctrl_r[lcd_drive_pkg::DUTY_LO_BIT]};
   assign com_par = pin_ctrl_r[lcd_drive_pkg::COM_PAR_BIT];
   assign exp_sel = pin_ctrl_r[lcd_drive_pkg::EXP_SEL_BIT];
   assign grp_sel = pin_ctrl_r[3:0];
   assign power_sw = control_r[lcd_drive_pkg::POWER_SW_BIT];
   assign activate = control_r[lcd_drive_pkg::ACTIVATE_BIT];
   assign show = control_r[lcd_drive_pkg::SHOW_BIT];
   assign clk_sel = control_r[3:0];
   assign use_sys = clk_sel[3];

   // ------------------------------------------------------------
   // Bus slave: writes complete with no wait, reads take one wait
   // ------------------------------------------------------------
   assign addr_ok = (haddr[31:8] == 24'h000000) && (haddr[1:0] == 2'h0);

   always_ff @(posedge clk) begin
      if (reset) begin
         wr_pend_r <= 1'b0;
         wr_addr_r <= 8'h00;
      end else begin
         wr_pend_r <= hsel && htrans[1] && hready && hwrite && addr_ok;
         wr_addr_r <= haddr[7:0];
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         rd_wait_r <= 1'b0;
         rd_addr_r <= 8'h00;
         hreadyout_r <= 1'b1;
      end else begin
         rd_wait_r <= hsel && htrans[1] && hready && !hwrite;
         if (hsel && htrans[1] && hready && !hwrite) begin
            rd_addr_r <= addr_ok ? haddr[7:0] : 8'hff;
         end
         hreadyout_r <= !(hsel && htrans[1] && hready && !hwrite);
      end
   end

   // The wait cycle lets a write just before a read land first
   always_ff @(posedge clk) begin
      if (reset) begin
         hrdata_r <= 32'h00000000;
      end else if (rd_wait_r) begin
         unique case (rd_addr_r)
            lcd_drive_pkg::OFS_PIN_CTRL: hrdata_r <= {24'h000000, pin_ctrl_r};
            lcd_drive_pkg::OFS_CONTROL:
               hrdata_r <= {24'h000000, lcd_drive_pkg::CONTROL_FIXED_ONES | {1'b0, control_r}};
            lcd_drive_pkg::OFS_STANDBY:
               hrdata_r <= {24'h000000, lcd_drive_pkg::STANDBY_FIXED_ONES | {7'h00, standby_n_r}};
            lcd_drive_pkg::OFS_STATUS:
               hrdata_r <= {24'h000000, 4'h0, alt_r, power_r, com_idx_r == 2'h0, running};
            default: hrdata_r <= 32'h00000000;
         endcase
      end
   end

   // Expansion bit is writable everywhere; parts without it must leave it alone
   always_ff @(posedge clk) begin
      if (reset) begin
         pin_ctrl_r <= lcd_drive_pkg::PIN_CTRL_RESET;
      end else if (wr_pend_r && wr_addr_r == lcd_drive_pkg::OFS_PIN_CTRL) begin
         pin_ctrl_r <= hwdata[7:0];
      end
   end

   // Clearing activate only halts the engine; nothing here is cleared
   always_ff @(posedge clk) begin
      if (reset) begin
         control_r <= lcd_drive_pkg::CONTROL_RESET[6:0];
      end else if (wr_pend_r && wr_addr_r == lcd_drive_pkg::OFS_CONTROL) begin
         control_r <= hwdata[6:0];
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         standby_n_r <= lcd_drive_pkg::STANDBY_N_RESET;
      end else if (wr_pend_r && wr_addr_r == lcd_drive_pkg::OFS_STANDBY) begin
         standby_n_r <= hwdata[lcd_drive_pkg::STANDBY_N_BIT];
      end
   end

   // ------------------------------------------------------------
   // Sub-clock pin: three stages, a change counts once stages agree
   // ------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (reset) begin
         sub_sync_r <= 3'h0;
         sub_level_r <= 1'b0;
         sub_tick_r <= 1'b0;
      end else begin
         sub_sync_r <= {sub_sync_r[1:0], subclk_pin};
         if (sub_sync_r[1] == sub_sync_r[2]) begin
            sub_level_r <= sub_sync_r[2];
         end
         sub_tick_r <= (sub_sync_r[1] == sub_sync_r[2]) && sub_sync_r[2] && !sub_level_r;
      end
   end

   // ------------------------------------------------------------
   // Operating clock selection
   // ------------------------------------------------------------
   // System selections produce nothing while the system clock is stopped
   assign running = activate && standby_n_r && !standby_mode
                    && !(use_sys && system_clock_stopped);
   assign restart = cfg_prev_r != {activate, clk_sel};

   // Divider by 2 to the power (code + 1): tick when those low bits are all ones
   assign sys_mask = 8'((9'h002 << clk_sel[2:0]) - 9'h001);

   always_comb begin
      unique case (clk_sel[1:0])
         2'h0: op_tick = sub_tick_r;
         2'h1: op_tick = sub_tick_r && sub_div_r[0];
         default: op_tick = sub_tick_r && (sub_div_r == 2'h3);
      endcase
      if (use_sys) begin
         op_tick = (sys_div_r & sys_mask) == sys_mask;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         sys_div_r <= 8'h00;
         sub_div_r <= 2'h0;
         cfg_prev_r <= 5'h00;
      end else begin
         cfg_prev_r <= {activate, clk_sel};
         if (!running || restart) begin
            sys_div_r <= 8'h00;
            sub_div_r <= 2'h0;
         end else begin
            sys_div_r <= sys_div_r + 8'h01;
            if (sub_tick_r) begin
               sub_div_r <= sub_div_r + 2'h1;
            end
         end
      end
   end

   // ------------------------------------------------------------
   // Frame timing: one phase per common
   // ------------------------------------------------------------
   // Sub frame is 256 ticks (128 Hz at 32.768 kHz), system frame twice that
   always_comb begin
      unique case (duty)
         lcd_drive_pkg::DUTY_STATIC: phase_len = 9'h004 * lcd_drive_pkg::SUB_QUARTER_PHASE;
         lcd_drive_pkg::DUTY_HALF: phase_len = 9'h002 * lcd_drive_pkg::SUB_QUARTER_PHASE;
         default: phase_len = lcd_drive_pkg::SUB_QUARTER_PHASE;
      endcase
      if (use_sys) begin
         phase_len = 9'(phase_len << 1);
      end
   end

   assign last_com = duty;
   assign phase_end = op_tick && (phase_cnt_r == 9'(phase_len - 9'h001));

   always_ff @(posedge clk) begin
      if (reset) begin
         phase_cnt_r <= 9'h000;
         com_idx_r <= 2'h0;
         alt_r <= 1'b0;
         frame_r <= 1'b0;
      end else if (!running || restart) begin
         phase_cnt_r <= 9'h000;
         com_idx_r <= 2'h0;
         frame_r <= 1'b0;
      end else begin
         frame_r <= phase_end && (com_idx_r >= last_com);
         if (op_tick) begin
            phase_cnt_r <= phase_end ? 9'h000 : phase_cnt_r + 9'h001;
         end
         if (phase_end) begin
            if (com_idx_r >= last_com) begin
               com_idx_r <= 2'h0;
               alt_r <= !alt_r;
            end else begin
               com_idx_r <= com_idx_r + 2'h1;
            end
         end
      end
   end

   // ------------------------------------------------------------
   // Commons
   // ------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (reset) begin
         com_out_r <= 4'h0;
      end else if (!running) begin
         com_out_r <= 4'h0;
      end else if (com_par && duty == lcd_drive_pkg::DUTY_STATIC) begin
         com_out_r <= 4'hf;
      end else if (com_par && duty == lcd_drive_pkg::DUTY_HALF) begin
         com_out_r <= com_idx_r[0] ? 4'hc : 4'h3;
      end else begin
         com_out_r <= 4'(4'h1 << com_idx_r);
      end
   end

   // ------------------------------------------------------------
   // Segment pins
   // ------------------------------------------------------------
   always_comb begin
      if (grp_sel[3]) begin
         groups_on = 3'h5;
      end else if (grp_sel[2:1] != 2'h0) begin
         groups_on = {1'b0, grp_sel[2:1]} + 3'h1;
      end else begin
         groups_on = {2'h0, grp_sel[0]};
      end
      if (exp_sel) begin
         groups_on = 3'h0;
      end
   end

   // Any nonzero group code with expansion on leaves every pin a port
   assign exp_active = exp_sel && (grp_sel == 4'h0);

   genvar i;
   generate
      for (i = 0; i < lcd_drive_pkg::SEG_PINS; i++) begin : g_seg
         localparam int GRP = (lcd_drive_pkg::SEG_PINS - 1 - i) / lcd_drive_pkg::GROUP_PINS;
         localparam logic [2:0] GRP_ID = 3'(GRP);
         always_ff @(posedge clk) begin
            if (reset) begin
               seg_oe_r[i] <= 1'b0;
               seg_out_r[i] <= 1'b0;
            end else if (exp_active && i >= lcd_drive_pkg::SEG_PINS - 4) begin
               seg_oe_r[i] <= 1'b1;
               unique case (i)
                  39: seg_out_r[i] <= frame_r;
                  38: seg_out_r[i] <= op_tick && running;
                  37: seg_out_r[i] <= running && show && seg_data[i];
                  default: seg_out_r[i] <= alt_r;
               endcase
            end else if (GRP_ID < groups_on) begin
               seg_oe_r[i] <= 1'b1;
               seg_out_r[i] <= running && show && seg_data[i];
            end else begin
               seg_oe_r[i] <= 1'b0;
               seg_out_r[i] <= 1'b0;
            end
         end
      end
   endgenerate

   // ------------------------------------------------------------
   // Drive supply
   // ------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (reset) begin
         power_r <= 1'b0;
      end else begin
         power_r <= power_sw && activate && standby_n_r && !standby_mode;
      end
   end

   assign hrdata = hrdata_r;
   assign hreadyout = hreadyout_r;
   assign hresp = 1'b0;
   assign seg_out = seg_out_r;
   assign seg_oe = seg_oe_r;
   assign com_out = com_out_r;
   assign drive_power_on = power_r;
   assign frame_pulse = frame_r;

endmodule

`default_nettype wire

// ---- tb/lcd_ctl_properties.sv ----
// Checker of bus and pin timing properties
`timescale 1ns/10ps
`default_nettype none
module lcd_ctl_props (
   input wire logic clk,
   input wire logic reset,
   input wire logic hsel,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic standby_mode,
   input wire logic [39:0] seg_oe,
   input wire logic [3:0] com_out,
   input wire logic drive_power_on,
   input wire logic frame_pulse
);
   // ------------------------------
   // Properties
   // ------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);
   logic req;
   assign req = hsel && htrans[1] && hready;
   property p_rst;
      $fell(reset) |-> seg_oe == 40'h0 && !drive_power_on && com_out == 4'h0;
   endproperty
   a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
   property p_grp;
      |seg_oe[31:0] |-> &seg_oe[39:32];
   endproperty
   a_grp: assert property (p_grp) else $error("lower group driven without top");
   property p_grp2;
      |seg_oe[7:0] |-> &seg_oe[39:8];
   endproperty
   a_grp2: assert property (p_grp2) else $error("bottom group out of order");
   property p_exp;
      |seg_oe[35:32] |-> &seg_oe[39:36];
   endproperty
   a_exp: assert property (p_exp) else $error("top four pins not driven");
   property p_stby;
      standby_mode [*3] |-> !drive_power_on && com_out == 4'h0 && !frame_pulse;
   endproperty
   a_stby: assert property (p_stby) else $error("active during standby");
   property p_pulse;
      frame_pulse |=> !frame_pulse;
   endproperty
   a_pulse: assert property (p_pulse) else $error("frame pulse too long");
   property p_rd;
      req && !hwrite |=> !hreadyout ##1 hreadyout;
   endproperty
   a_rd: assert property (p_rd) else $error("read wait state wrong");
   property p_wr;
      req && hwrite |=> hreadyout;
   endproperty
   a_wr: assert property (p_wr) else $error("write stalled");
   c_frame: cover property (frame_pulse);
   c_pwr: cover property (drive_power_on);
   c_rd: cover property (req && !hwrite);
endmodule
bind lcd_segment_drive_control lcd_ctl_props lcd_ctl_props_inst (.clk(clk), .reset(reset),
   .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
   .standby_mode(standby_mode), .seg_oe(seg_oe), .com_out(com_out),
   .drive_power_on(drive_power_on), .frame_pulse(frame_pulse));
`default_nettype wire

// ---- tb/lcd_panel_model.sv ----
// Model of the glass: sub-clock source and lit frame count
`timescale 1ns/10ps
`default_nettype none
module lcd_panel_model (
   input wire logic clk,
   input wire logic drive_power_on,
   input wire logic frame_pulse,
   output logic subclk,
   output int lit_frames
);
   initial subclk = 1'b0;
   initial lit_frames = 0;
   // Free running 32.768 kHz crystal, unrelated to clk
   always #15259 subclk = ~subclk;
   // Glass shows a frame only while its supply is up
   always @(posedge clk) begin
      if (frame_pulse && drive_power_on) begin
         lit_frames <= lit_frames + 1;
      end
   end
endmodule
`default_nettype wire

// ---- tb/test_lcd_segment_drive_control.sv ----
// Bench for the segment LCD drive control block
`timescale 1ns/10ps
`default_nettype none
module test_lcd_segment_drive_control;
   localparam logic [7:0] PR = lcd_drive_pkg::OFS_PIN_CTRL;
   localparam logic [7:0] CR = lcd_drive_pkg::OFS_CONTROL;
   localparam logic [7:0] SR = lcd_drive_pkg::OFS_STANDBY;
   localparam int FT = lcd_drive_pkg::SYS_FRAME_TICKS;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic stby = 1'b0;
   logic stop = 1'b0;
   logic [39:0] seg_data = 40'hff00ff00ff;
   logic [31:0] hrdata;
   logic hreadyout;
   logic [39:0] seg_out;
   logic [39:0] seg_oe;
   logic [3:0] com_out;
   logic pwr;
   logic fp;
   logic subclk;
   int lit_frames;
   int bad_count = 0;
   int n_checks = 0;
   int cyc = 0;
   int n;
   logic [31:0] q;
   always #5 clk = ~clk;
   lcd_segment_drive_control lcd_segment_drive_control_inst (.clk(clk), .reset(reset),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
      .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(), .subclk_pin(subclk), .standby_mode(stby), .system_clock_stopped(stop),
      .seg_data(seg_data), .seg_out(seg_out), .seg_oe(seg_oe), .com_out(com_out),
      .drive_power_on(pwr), .frame_pulse(fp));
   lcd_panel_model lcd_panel_model_inst (.clk(clk), .drive_power_on(pwr),
      .frame_pulse(fp), .subclk(subclk), .lit_frames(lit_frames));
   // ------------------------------
   // Tasks
   // ------------------------------
   task automatic chk(input string nm, input logic [39:0] seen, input logic [39:0] exp);
      n_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("mismatch %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   // Ready is taken from the half cycle before the edge, where it is settled
   task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
      logic r;
      @(posedge clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= w;
      do begin
         @(negedge clk);
         r = hreadyout;
         @(posedge clk);
      end while (r !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= {24'h0, d};
      do begin
         @(negedge clk);
         r = hreadyout;
         q = hrdata;
         @(posedge clk);
      end while (r !== 1'b1);
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      bus(1'b0, a, 8'h0);
      chk("register", {8'h0, q}, {32'h0, e});
   endtask
   task automatic settle;
      repeat (3) @(posedge clk);
      @(negedge clk);
   endtask
   // Interval between the second and third pulse, so restarts are excluded
   task automatic period(input int lim, output int p);
      for (int i = 0; i < 3; i++) begin
         p = 0;
         do begin
            @(negedge clk);
            p++;
         end while (fp !== 1'b1 && p < lim);
      end
   endtask
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 80000) begin
         bad_count++;
         print_verdict();
      end
   end
   // ------------------------------
   // Tests
   // ------------------------------
   initial begin
      repeat (16) @(posedge clk);
      reset <= 1'b0;
      rd(CR, 8'h80);
      rd(PR, 8'h00);
      rd(SR, 8'hff);
      rd(8'h10, 8'h00);
      bus(1'b1, CR, 8'h00);
      rd(CR, 8'h80);
      $display("test registers done");
      bus(1'b1, CR, 8'h38);
      for (int c = 0; c < 16; c++) begin
         n = (c == 0) ? 0 : (c == 1) ? 1 : c[3] ? 5 : int'(c[2:1]) + 1;
         bus(1'b1, PR, 8'(c));
         settle();
         chk("seg_oe", seg_oe, ~({40{1'b1}} >> (8 * n)));
      end
      chk("seg_out", seg_out, seg_data);
      chk("com", com_out, 4'h1);
      bus(1'b1, PR, 8'h2f);
      settle();
      chk("com", com_out, 4'hf);
      bus(1'b1, CR, 8'h20);
      settle();
      chk("seg_out", seg_out, 40'h0);
      bus(1'b1, PR, 8'h10);
      settle();
      chk("seg_oe", seg_oe, 40'hf000000000);
      // Shift clock pin follows the sub-clock tick, one per crystal period
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (seg_out[38] !== 1'b1 && n < 4000);
      chk("shift", 40'(n < 3200), 40'h1);
      bus(1'b1, PR, 8'h00);
      settle();
      chk("seg_oe", seg_oe, 40'h0);
      $display("test pins done");
      bus(1'b1, CR, 8'h68);
      settle();
      chk("power", pwr, 1'b1);
      @(posedge clk);
      stby <= 1'b1;
      settle();
      chk("power", pwr, 1'b0);
      @(posedge clk);
      stby <= 1'b0;
      bus(1'b1, SR, 8'h00);
      settle();
      chk("power", pwr, 1'b0);
      rd(SR, 8'hfe);
      bus(1'b1, SR, 8'h01);
      bus(1'b1, CR, 8'h48);
      settle();
      chk("power", pwr, 1'b0);
      chk("com", com_out, 4'h0);
      rd(CR, 8'hc8);
      bus(1'b1, CR, 8'h28);
      settle();
      chk("power", pwr, 1'b0);
      $display("test power done");
      for (int k = 0; k < 3; k++) begin
         bus(1'b1, CR, 8'h78 + 8'(k));
         period(9000, n);
         chk("frame", 40'(n), 40'(FT * (2 << k)));
      end
      bus(1'b1, PR, 8'h80);
      bus(1'b1, CR, 8'h78);
      period(9000, n);
      chk("frame", 40'(n), 40'(FT * 2 * 3 / 4));
      chk("lit", 40'(lit_frames != 0), 40'h1);
      @(posedge clk);
      stop <= 1'b1;
      period(1500, n);
      chk("frame", 40'(n), 40'd1500);
      $display("test frames done");
      print_verdict();
   end
endmodule
`default_nettype wire
